/* File: rtl/tcf_top.sv */
// channel formatting and cold junction compensation engine with its register port
// assumes samples from the front end on mclk: microvolts for channels 0..5, RTD tenths C on channel 9
`timescale 1ns/1ns
module tcf_top (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sample_valid,
	input wire logic [3:0] sample_ch,
	input wire logic signed [23:0] sample_data,
	input wire logic rtd_break,
	output logic sample_ready,
	output logic code_valid,
	output logic [2:0] code_ch,
	output logic [15:0] code_data,
	output tcf_pkg::tcf_sensor_e cjc_sensor_type,
	output logic irq
);
	import tcf_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_MV = 4'h1, S_F1 = 4'h2, S_F2 = 4'h3, S_RI = 4'h4,
		S_RC = 4'h5, S_DA = 4'h6, S_D0 = 4'h7, S_D1 = 4'h8, S_DIV = 4'h9, S_OUT = 4'ha
	} tcf_state_e;

	tcf_tbl_if tbl ();

	tcf_tbl_mem #(.DEPTH(TBL_TYPES * TBL_NPTS)) u_mem (
		.mclk(mclk),
		.tbl(tbl.mem)
	);

	////////////////////////////////////////////////////////////////////////////
	// configuration and status storage
	logic scale_f, src_fixed, break_det_en;
	logic [23:0] range_reg;
	logic [5:0] cjc_en;
	logic [15:0] fixed_val;
	logic [TBL_AW-1:0] tbl_addr;
	logic [ST_W-1:0] status, mask;
	logic signed [15:0] cj_c10;
	logic [7:0] diag_cj;
	logic [15:0] codes [NCH];
	logic cfg_bad_q;

	// engine state
	tcf_state_e state;
	logic [2:0] ch;
	logic [3:0] typ;
	logic scale_q;
	logic signed [23:0] val_uv;
	logic signed [24:0] mv_sum;
	logic signed [23:0] m0;
	logic [7:0] frac;
	logic [6:0] idx_f, lo;
	logic [2:0] bitn;
	logic [24:0] den;
	logic [25:0] rem;
	logic [7:0] quo;
	logic [3:0] div_cnt;

	////////////////////////////////////////////////////////////////////////////
	// register port decode
	wire wr_ctrl = wr && addr == REG_CTRL;
	wire wr_range = wr && addr == REG_RANGE;
	wire wr_cjc_en = wr && addr == REG_CJC_EN;
	wire wr_fixed = wr && addr == REG_FIXED;
	wire wr_taddr = wr && addr == REG_TBL_ADDR;
	wire wr_tdata = wr && addr == REG_TBL_DATA;
	wire wr_mask = wr && addr == REG_MASK;
	wire rd_status = rd && addr == REG_STATUS;
	wire [2:0] code_sel = 3'(addr - REG_CODE0);
	wire [31:0] rd_mux =
		(addr == REG_CTRL) ? {27'h0, break_det_en, cjc_sensor_type, src_fixed, scale_f} :
		(addr == REG_RANGE) ? {8'h00, range_reg} :
		(addr == REG_CJC_EN) ? {26'h0, cjc_en} :
		(addr == REG_FIXED) ? {16'h0000, fixed_val} :
		(addr == REG_TBL_ADDR) ? {21'h0, tbl_addr} :
		(addr == REG_STATUS) ? {29'h0, status} :
		(addr == REG_MASK) ? {29'h0, mask} :
		(addr == REG_CJ_TEMP) ? {{16{cj_c10[15]}}, cj_c10} :
		(addr == REG_DIAG) ? {24'h0, diag_cj} :
		(addr >= REG_CODE0) ? {16'h0000, codes[code_sel]} : 32'h0;

	// table loading goes straight to the memory, address steps after each word
	assign tbl.wr_en = wr_tdata;
	assign tbl.wr_addr = tbl_addr;
	assign tbl.wr_data = wdata[TBL_DW-1:0];

	////////////////////////////////////////////////////////////////////////////
	// fixed value checks and scale conversion
	wire fix_ok_c = fixed_val <= FIX_C_MAX;
	wire fix_ok_f = fixed_val >= FIX_F_MIN && fixed_val <= FIX_F_MAX;
	wire fixed_ok = scale_f ? fix_ok_f : fix_ok_c;
	wire [31:0] fix_f_prod = 32'(16'(fixed_val - FIX_F_MIN)) * F_TO_C_K;
	wire signed [15:0] fix_c10 = scale_f ? 16'(fix_f_prod >> 16) : fixed_val;
	wire cfg_bad = src_fixed && !fixed_ok && cjc_en != 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// sample intake decode
	wire take_field = sample_valid && sample_ready && sample_ch < 4'(NCH);
	wire take_cj = sample_valid && sample_ch == CJC_CH;
	wire [3:0] in_rng = range_reg[4 * sample_ch[2:0] +: 4];
	wire in_is_tc = in_rng <= RNG_C;
	wire in_is_mv = in_rng == RNG_MV90 || in_rng == RNG_MV44;
	wire in_comp = in_is_tc && cjc_en[sample_ch[2:0]] && (!src_fixed || fixed_ok);
	wire signed [15:0] in_cj = src_fixed ? fix_c10 : cj_c10;
	wire [15:0] cj_off = 16'(in_cj - 16'(TBL_T0_C10));
	wire break_now = break_det_en && rtd_break;
	wire signed [15:0] cj_clamp = (sample_data < 0) ? 16'sd0 :
		(sample_data > 24'(CJ_MAX_C10)) ? CJ_MAX_C10 : 16'(sample_data);

	////////////////////////////////////////////////////////////////////////////
	// engine arithmetic
	wire [6:0] cand = lo | (7'h01 << bitn);
	wire signed [23:0] tbl_val = $signed(tbl.rd_data);
	wire cand_le = cand <= TBL_LAST_LO && 25'(tbl_val) <= mv_sum;
	wire signed [33:0] slope = 34'(tbl_val - m0) * $signed({26'h0, frac});
	wire signed [24:0] mv_cj = 25'(m0) + 25'(slope >>> 8);
	wire signed [24:0] num_s = mv_sum - 25'(m0);
	wire signed [24:0] den_s = 25'(tbl_val) - 25'(m0);
	wire [24:0] num = (num_s < 0) ? 25'h0 : num_s;
	wire [25:0] rem_sh = {rem[24:0], 1'b0};
	wire rem_ge = rem_sh >= {1'b0, den};
	wire signed [17:0] t_out = 18'(TBL_T0_C10) + 18'({lo, quo});
	wire [15:0] out_code = (state == S_MV) ? tcf_mv_code(val_uv, typ == RNG_MV90) : tcf_temp_code(t_out, scale_q);

	// table read address per state
	assign tbl.rd_en = state == S_IDLE || state == S_F1 || state == S_RI || state == S_DA || state == S_D0;
	assign tbl.rd_addr =
		(state == S_IDLE) ? {in_rng, cj_off[14:8]} :
		(state == S_F1) ? {typ, 7'(idx_f + 7'd1)} :
		(state == S_RI) ? {typ, cand} :
		(state == S_DA) ? {typ, lo} : {typ, 7'(lo + 7'd1)};

	////////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge mclk) begin
		if (srst) begin
			{break_det_en, cjc_sensor_type, src_fixed, scale_f} <= {CTRL_RESET[4], tcf_sensor_e'(CTRL_RESET[3:2]),
				CTRL_RESET[1], CTRL_RESET[0]};
			range_reg <= RANGE_RESET;
			cjc_en <= CJC_EN_RESET;
			fixed_val <= FIXED_RESET;
			tbl_addr <= '0;
			mask <= '0;
		end else begin
			if (wr_ctrl) begin
				scale_f <= wdata[CTRL_SCALE_F];
				src_fixed <= wdata[CTRL_SRC_FIXED];
				cjc_sensor_type <= tcf_sensor_e'(wdata[CTRL_SENSOR_LO +: 2]);
				break_det_en <= wdata[CTRL_BREAK_EN];
			end
			if (wr_range)
				range_reg <= wdata[23:0];
			if (wr_cjc_en)
				cjc_en <= wdata[5:0];
			if (wr_fixed)
				fixed_val <= wdata[15:0];
			if (wr_taddr)
				tbl_addr <= wdata[TBL_AW-1:0];
			else if (wr_tdata)
				tbl_addr <= tbl_addr + 1'b1;
			if (wr_mask)
				mask <= wdata[ST_W-1:0];
		end
	end

	// read data one cycle after the strobe; status clears on read, new events win
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata <= 32'h0;
			status <= '0;
			irq <= 1'b0;
			cfg_bad_q <= 1'b0;
		end else begin
			rdata <= rd ? rd_mux : 32'h0;
			cfg_bad_q <= cfg_bad;
			status <= (rd_status ? '0 : status) | {cfg_bad && !cfg_bad_q,
				take_cj && break_now && diag_cj != DIAG_BREAK, state == S_MV || state == S_OUT};
			irq <= |(status & mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cold junction channel: hold last good value on a detected break
	always_ff @(posedge mclk) begin
		if (srst) begin
			cj_c10 <= 16'sd0;
			diag_cj <= DIAG_OK;
		end else if (take_cj) begin
			if (break_now) begin
				diag_cj <= DIAG_BREAK;
			end else begin
				cj_c10 <= cj_clamp;
				diag_cj <= DIAG_OK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion state machine
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= S_IDLE;
			sample_ready <= 1'b1;
			code_valid <= 1'b0;
			{ch, typ, scale_q, val_uv, mv_sum, m0, frac, idx_f, lo, bitn} <= '0;
			{den, rem, quo, div_cnt, code_ch, code_data} <= '0;
			for (int i = 0; i < NCH; i++) begin
				codes[i] <= 16'h0000;
			end
		end else begin
			code_valid <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (take_field && (in_is_tc || in_is_mv)) begin
						ch <= sample_ch[2:0];
						typ <= in_rng;
						scale_q <= scale_f;
						val_uv <= sample_data;
						mv_sum <= 25'(sample_data);
						idx_f <= cj_off[14:8];
						frac <= cj_off[7:0];
						lo <= '0;
						bitn <= 3'd6;
						sample_ready <= 1'b0;
						state <= in_is_mv ? S_MV : in_comp ? S_F1 : S_RI;
					end
				end
				S_F1: begin
					m0 <= tbl_val;
					state <= S_F2;
				end
				S_F2: begin
					mv_sum <= 25'(val_uv) + mv_cj;
					state <= S_RI;
				end
				S_RI: state <= S_RC;
				S_RC: begin
					if (cand_le)
						lo <= cand;
					bitn <= bitn - 3'd1;
					state <= (bitn == 3'd0) ? S_DA : S_RI;
				end
				S_DA: state <= S_D0;
				S_D0: begin
					m0 <= tbl_val;
					state <= S_D1;
				end
				S_D1: begin
					den <= (den_s <= 0) ? 25'd1 : den_s;
					rem <= {1'b0, num};
					quo <= 8'h00;
					div_cnt <= 4'd8;
					state <= (den_s > 0 && num >= den_s) ? S_OUT : S_DIV;
					if (den_s > 0 && num >= den_s)
						quo <= 8'hff;
				end
				S_DIV: begin
					rem <= rem_ge ? rem_sh - {1'b0, den} : rem_sh;
					quo <= {quo[6:0], rem_ge};
					div_cnt <= div_cnt - 4'd1;
					if (div_cnt == 4'd1)
						state <= S_OUT;
				end
				S_MV, S_OUT: begin
					codes[ch] <= out_code;
					code_data <= out_code;
					code_ch <= ch;
					code_valid <= 1'b1;
					sample_ready <= 1'b1;
					state <= S_IDLE;
				end
				default: begin
					sample_ready <= 1'b1;
					state <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	chk_break_hold_value: assert property (take_cj && break_now |=> $stable(cj_c10))
		else $error("cold junction value changed during line break");
	chk_break_diag_byte: assert property (take_cj && break_now |=> diag_cj == 8'd166)
		else $error("line break diagnosis byte wrong");
	chk_fixed_celsius_range: assert property (!scale_f && fixed_val > 16'd600 |-> !fixed_ok)
		else $error("celsius fixed value above 600 accepted");
	chk_fixed_fahr_range: assert property (scale_f && fixed_val >= 16'd320 && fixed_val <= 16'd1400
		|-> fixed_ok)
		else $error("fahrenheit fixed value in range refused");
	chk_mv_full_scale: assert property (take_field && in_rng == RNG_MV90 && sample_data == 24'sd78000
		|-> ##2 code_valid && code_data == 16'hffff)
		else $error("wide millivolt full scale not 65535");
	chk_mv_zero_scale: assert property (take_field && in_rng == RNG_MV44 && sample_data == -24'sd12000
		|-> ##2 code_valid && code_data == 16'h0000)
		else $error("narrow millivolt bottom not zero");
	chk_tc_done_bound: assert property (take_field && in_is_tc |-> ##[4:40] code_valid)
		else $error("thermocouple conversion did not finish");
	chk_comp_gate: assert property (take_field && in_is_tc && !cjc_en[sample_ch[2:0]] |=> state == S_RI)
		else $error("compensation ran on a disabled channel");
	chk_bad_fixed_skip: assert property (take_field && src_fixed && !fixed_ok |=> state != S_F1)
		else $error("invalid fixed value applied");

	// sample routing and busy behaviour
	chk_mv_route: assert property (take_field && in_is_mv |=> state == S_MV)
		else $error("millivolt sample sent through the table path");
	chk_mv_two_cycles: assert property (take_field && in_is_mv |-> ##2 code_valid && code_ch == ch)
		else $error("millivolt code late or on the wrong channel");
	chk_tc_path: assert property (take_field && in_is_tc |=> state == S_F1 || state == S_RI)
		else $error("thermocouple sample skipped the table path");
	chk_comp_enabled: assert property (take_field && in_comp |=> state == S_F1)
		else $error("enabled compensation not applied");
	chk_ready_idle: assert property (sample_ready |-> state == S_IDLE)
		else $error("sample port ready while converting");
	chk_busy_channel: assert property (!sample_ready |=> $stable(ch))
		else $error("channel changed during a conversion");

	// cold junction channel
	chk_cj_clamped: assert property (take_cj && !break_now |=> cj_c10 >= 16'sh0000 && cj_c10 <= 16'sh0258)
		else $error("cold junction value outside 0 to 60 C");
	chk_diag_recover: assert property (take_cj && !break_now |=> diag_cj == 8'ha0)
		else $error("diagnosis not back to ok on a good sample");
	chk_break_status: assert property (take_cj && break_now && diag_cj == 8'ha0 |=> status[ST_BREAK])
		else $error("line break event not flagged");

	// fixed value limits
	chk_fixed_fahr_out: assert property (scale_f && (fixed_val < 16'h0140 || fixed_val > 16'h0578)
		|-> !fixed_ok)
		else $error("fahrenheit fixed value out of range accepted");
	chk_cfg_status: assert property (cfg_bad && !cfg_bad_q |=> status[ST_CFG])
		else $error("configuration error not flagged");

	// output pulse and interrupt level
	chk_code_one_pulse: assert property (code_valid |=> !code_valid)
		else $error("code valid longer than one cycle");
	chk_irq_follows: assert property (irq == |($past(status) & $past(mask)))
		else $error("interrupt does not follow masked status");

endmodule : tcf_top

/* File: rtl/tcf_pkg.sv */
// constants, types and shared arithmetic for thermocouple data formatting and cold junction compensation
// assumes one 100 MHz clock mclk with synchronous active-high reset srst
// How it works
// - every channel result is a plain 16-bit unsigned code, 0 to 65535
// - ranges: thermocouple B, E, J, K, R, S, T, N, C and two millivolt spans
// - millivolt code scales linearly: mV = code/65535 * span - 12, span 90 or 44
// - thermocouple code is ten times temperature plus 10000
// - compensation only runs on channels set to a thermocouple range
// - RTD mode: cold junction temperature to mV, add, reverse table to temperature
// - cold junction RTD samples arrive as internal channel nine
// - RTD type selectable copper 50 or two platinum 100; compensation held to 0..60 C
// - each channel has its own compensation enable
// - a source bit picks measured RTD or fixed configured cold junction temperature
// - break detect defaults off; on break hold last good value, flag diagnosis
// - fixed mode uses the configured value through the same table procedure
// - the fixed value is read in the selected scale, Celsius or Fahrenheit
// - Celsius fixed value is valid from 0 to 600
// - Fahrenheit fixed value is valid from 320 to 1400
// - a broken RTD line shows diagnosis byte 166
package tcf_pkg;

	localparam int NCH = 6;
	localparam logic [3:0] CJC_CH = 4'h9;

	// register word indices on the plain port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_RANGE = 4'h1;
	localparam logic [3:0] REG_CJC_EN = 4'h2;
	localparam logic [3:0] REG_FIXED = 4'h3;
	localparam logic [3:0] REG_TBL_ADDR = 4'h4;
	localparam logic [3:0] REG_TBL_DATA = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam logic [3:0] REG_MASK = 4'h7;
	localparam logic [3:0] REG_CJ_TEMP = 4'h8;
	localparam logic [3:0] REG_DIAG = 4'h9;
	localparam logic [3:0] REG_CODE0 = 4'ha;

	// control register fields
	localparam int CTRL_SCALE_F = 0;
	localparam int CTRL_SRC_FIXED = 1;
	localparam int CTRL_SENSOR_LO = 2;
	localparam int CTRL_BREAK_EN = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [23:0] RANGE_RESET = 24'h999999;
	localparam logic [5:0] CJC_EN_RESET = 6'h00;
	localparam logic [15:0] FIXED_RESET = 16'h0000;

	// status bits
	localparam int ST_CODE = 0;
	localparam int ST_BREAK = 1;
	localparam int ST_CFG = 2;
	localparam int ST_W = 3;

	typedef enum logic [3:0] {
		RNG_B = 4'h0, RNG_E = 4'h1, RNG_J = 4'h2, RNG_K = 4'h3, RNG_R = 4'h4,
		RNG_S = 4'h5, RNG_T = 4'h6, RNG_N = 4'h7, RNG_C = 4'h8,
		RNG_MV90 = 4'h9, RNG_MV44 = 4'ha
	} tcf_range_e;

	typedef enum logic [1:0] {SENS_CU50 = 2'h0, SENS_PT385 = 2'h1, SENS_PT3916 = 2'h2} tcf_sensor_e;

	// coding constants
	localparam int TC_CODE_OFFSET = 10000;
	localparam int MV_OFFSET_UV = 12000;
	localparam int SPAN90_UV = 90000;
	localparam int SPAN44_UV = 44000;
	localparam logic [47:0] MV_K90 = 48'((64'd65535 * 64'd1048576 + 64'd89999) / 64'd90000);
	localparam logic [47:0] MV_K44 = 48'((64'd65535 * 64'd1048576 + 64'd43999) / 64'd44000);
	localparam logic [35:0] C_TO_F_K = 36'd117965;
	localparam logic [31:0] F_TO_C_K = 32'd36409;
	localparam int F_OFFSET10 = 320;

	// fixed value and cold junction limits, tenths of a degree
	localparam logic [15:0] FIX_C_MAX = 16'd600;
	localparam logic [15:0] FIX_F_MIN = 16'd320;
	localparam logic [15:0] FIX_F_MAX = 16'd1400;
	localparam logic signed [15:0] CJ_MAX_C10 = 16'sd600;

	// diagnosis bytes
	localparam logic [7:0] DIAG_OK = 8'ha0;
	localparam logic [7:0] DIAG_BREAK = 8'ha6;

	// table: per type, points every 25.6 C from -200 C, microvolts
	localparam int TBL_TYPES = 9;
	localparam int TBL_NPTS = 128;
	localparam int TBL_AW = 11;
	localparam int TBL_DW = 24;
	localparam int TBL_T0_C10 = -2000;
	localparam logic [6:0] TBL_LAST_LO = 7'd126;

	// millivolt range code, clamped to 0..65535
	function automatic logic [15:0] tcf_mv_code(input logic signed [23:0] uv, input logic wide);
		logic signed [25:0] x;
		logic [47:0] p;
		x = 26'(uv) + 26'(MV_OFFSET_UV);
		p = 48'(x[24:0]) * (wide ? MV_K90 : MV_K44);
		if (x < 0)
			tcf_mv_code = 16'h0000;
		else if (p[47:36] != 12'h000)
			tcf_mv_code = 16'hffff;
		else
			tcf_mv_code = p[35:20];
	endfunction : tcf_mv_code

	// temperature code: tenths of degrees in the chosen scale plus offset
	function automatic logic [15:0] tcf_temp_code(input logic signed [17:0] t_c10, input logic scale_f);
		logic signed [35:0] s;
		logic signed [21:0] v;
		s = 36'(t_c10) * $signed(C_TO_F_K);
		v = scale_f ? 22'(s >>> 16) + 22'(F_OFFSET10) : 22'(t_c10);
		v = v + 22'(TC_CODE_OFFSET);
		if (v < 0)
			tcf_temp_code = 16'h0000;
		else if (v > 22'sd65535)
			tcf_temp_code = 16'hffff;
		else
			tcf_temp_code = v[15:0];
	endfunction : tcf_temp_code

endpackage : tcf_pkg

/* File: rtl/tcf_tbl_if.sv */
// lookup table port between the conversion engine and its table memory
// assumes both ends on mclk; read data one cycle after rd_en
`timescale 1ns/1ns
interface tcf_tbl_if;
	logic rd_en;
	logic [tcf_pkg::TBL_AW-1:0] rd_addr;
	logic [tcf_pkg::TBL_DW-1:0] rd_data;
	logic wr_en;
	logic [tcf_pkg::TBL_AW-1:0] wr_addr;
	logic [tcf_pkg::TBL_DW-1:0] wr_data;
	modport host (output rd_en, output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
	modport mem (input rd_en, input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : tcf_tbl_if

/* File: rtl/tcf_tbl_mem.sv */
// thermocouple millivolt table memory, one write and one registered read port
// assumes software loads every type before enabling thermocouple ranges
`timescale 1ns/1ns
module tcf_tbl_mem #(
	parameter int DEPTH = tcf_pkg::TBL_TYPES * tcf_pkg::TBL_NPTS
) (
	input wire logic mclk,
	tcf_tbl_if.mem tbl
);
	import tcf_pkg::*;

	if (DEPTH < TBL_TYPES * TBL_NPTS || DEPTH > (1 << TBL_AW)) begin : g_bad_depth
		$error("table depth cannot hold all types");
	end

	logic [TBL_DW-1:0] store [DEPTH];
	logic [TBL_DW-1:0] rd_q;

	////////////////////////////////////////////////////////////////////////////
	// write port and registered read port
	always_ff @(posedge mclk) begin
		if (tbl.wr_en && int'(tbl.wr_addr) < DEPTH)
			store[tbl.wr_addr] <= tbl.wr_data;
		if (tbl.rd_en)
			rd_q <= (int'(tbl.rd_addr) < DEPTH) ? store[tbl.rd_addr] : '0;
	end

	assign tbl.rd_data = rd_q;

endmodule : tcf_tbl_mem

/* File: dv/tcf_ctrl_model.sv */
// partner model: the controller side that collects channel codes
// assumes code_valid is a one-cycle pulse on mclk beside code_ch and code_data
`timescale 1ns/1ns
module tcf_ctrl_model (
	input wire logic mclk,
	input wire logic code_valid,
	input wire logic [2:0] code_ch,
	input wire logic [15:0] code_data,
	output logic [15:0] last_code,
	output logic [2:0] last_ch,
	output int n_codes
);
	initial begin
		n_codes = 0;
		last_code = 16'h0000;
		last_ch = 3'h0;
	end
	// take each code in the one cycle it stands, as a plain unsigned word
	always @(posedge mclk) begin
		if (code_valid === 1'b1) begin
			last_code <= code_data;
			last_ch <= code_ch;
			n_codes <= n_codes + 1;
		end
	end
endmodule : tcf_ctrl_model

/* File: dv/tcf_top_tb.sv */
// self-checking bench for the formatting and compensation engine
// assumes a linear table of 256 uV per 25.6 C step loaded for every type: 1 uV is 0.1 C
`timescale 1ns/1ns
module tcf_top_tb;
	import tcf_pkg::*;
	logic mclk, srst, wr, rd, sample_valid, rtd_break;
	logic [3:0] addr, sample_ch;
	logic [31:0] wdata, rdata;
	logic signed [23:0] sample_data;
	logic sample_ready, code_valid, irq;
	logic [2:0] code_ch, last_ch;
	logic [15:0] code_data, last_code;
	tcf_sensor_e sensor_type;
	int n_codes, miscompares, n_tests, cycles, i;
	logic [31:0] junk;
	int mv_rng[5] = '{9, 9, 9, 10, 10};
	int mv_uv[5] = '{-12000, 78000, 6000, -3200, 32000};
	int mv_exp[5] = '{0, 65535, 13107, 13107, 65535};
	int fx_val[3] = '{320, 1220, 1400};
	int fx_exp[3] = '{12120, 13020, 13200};

	tcf_top dut (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sample_valid(sample_valid), .sample_ch(sample_ch), .sample_data(sample_data), .rtd_break(rtd_break),
		.sample_ready(sample_ready), .code_valid(code_valid), .code_ch(code_ch), .code_data(code_data),
		.cjc_sensor_type(sensor_type), .irq(irq));
	tcf_ctrl_model mdl (.mclk(mclk), .code_valid(code_valid), .code_ch(code_ch), .code_data(code_data),
		.last_code(last_code), .last_ch(last_ch), .n_codes(n_codes));

	////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			miscompares = miscompares + 1;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////
	// register port: one-cycle strobes, read data in the cycle after rd
	task automatic wr_t(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_t
	task automatic rd_t(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		d = rdata;
	endtask : rd_t
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_t(a, d);
		chk(d, exp);
	endtask : rd_chk

	////////////////////////////////////////////////////////////////////////////
	// sample port: hold the strobe until taken, then wait a bounded time for the code
	task automatic send(input logic [3:0] ch, input int uv);
		int k;
		@(posedge mclk);
		sample_ch <= ch;
		sample_data <= 24'(uv);
		sample_valid <= 1'b1;
		@(posedge mclk);
		for (k = 0; k < 40 && ch < 4'h6 && sample_ready !== 1'b1; k++)
			@(posedge mclk);
		sample_valid <= 1'b0;
		for (k = 0; k < 60 && ch < 4'h6 && code_valid !== 1'b1; k++)
			@(posedge mclk);
	endtask : send
	// set channel 0 range, convert one sample, expect one code on channel 0
	task automatic code_chk(input logic [3:0] rng, input int uv, input logic [15:0] exp);
		int n0;
		wr_t(REG_RANGE, {8'h00, 20'h99999, rng});
		n0 = n_codes;
		send(4'h0, uv);
		@(posedge mclk);
		chk(32'(n_codes - n0), 32'h1);
		chk({13'h0000, last_ch, last_code}, {16'h0000, exp});
	endtask : code_chk

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		srst = 1'b1;
		{addr, wdata, wr, rd, sample_valid, sample_ch, sample_data, rtd_break} = '0;
		miscompares = 0;
		n_tests = 0;
		cycles = 0;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		rd_chk(REG_CTRL, 32'h0);
		rd_chk(REG_RANGE, 32'h00999999);
		rd_chk(REG_DIAG, 32'ha0);
		chk({31'h0, irq}, 32'h0);
		// identical linear table for every type
		wr_t(REG_TBL_ADDR, 32'h0);
		for (i = 0; i < TBL_TYPES * TBL_NPTS; i++)
			wr_t(REG_TBL_DATA, 32'((i % TBL_NPTS) * 256));
		rd_chk(REG_TBL_DATA, 32'h0);
		// millivolt spans, compensation enabled but not applied
		wr_t(REG_CJC_EN, 32'h1);
		for (i = 0; i < 5; i++)
			code_chk(4'(mv_rng[i]), mv_uv[i], 16'(mv_exp[i]));
		// every thermocouple type without compensation
		wr_t(REG_CJC_EN, 32'h0);
		for (i = 0; i < 9; i++)
			code_chk(4'(i), 3000, 16'd11000);
		rd_chk(REG_CODE0, 32'd11000);
		// measured cold junction, break detect still off
		wr_t(REG_CJC_EN, 32'h1);
		rtd_break <= 1'b1;
		send(CJC_CH, 250);
		rd_chk(REG_CJ_TEMP, 32'd250);
		rd_chk(REG_DIAG, 32'ha0);
		code_chk(4'h3, 1000, 16'd11250);
		send(CJC_CH, 700);
		rd_chk(REG_CJ_TEMP, 32'd600);
		// break detect on: value held, diagnosis flagged
		wr_t(REG_CTRL, 32'h18);
		@(posedge mclk);
		chk(32'(sensor_type), 32'(SENS_PT3916));
		rd_t(REG_STATUS, junk);
		send(CJC_CH, 100);
		rd_chk(REG_CJ_TEMP, 32'd600);
		rd_chk(REG_DIAG, 32'ha6);
		rd_chk(REG_STATUS, 32'h2);
		code_chk(4'h3, 1000, 16'd11600);
		rtd_break <= 1'b0;
		// fixed value in Celsius, then out of range
		wr_t(REG_CTRL, 32'h02);
		wr_t(REG_FIXED, 32'd300);
		code_chk(4'h3, 1000, 16'd11300);
		wr_t(REG_FIXED, 32'd600);
		code_chk(4'h3, 1000, 16'd11600);
		rd_t(REG_STATUS, junk);
		wr_t(REG_FIXED, 32'd601);
		code_chk(4'h3, 1000, 16'd9000);
		rd_chk(REG_STATUS, 32'h5);
		// fixed value in Fahrenheit across its span
		wr_t(REG_CTRL, 32'h03);
		for (i = 0; i < 3; i++) begin
			wr_t(REG_FIXED, 32'(fx_val[i]));
			code_chk(4'h3, 1000, 16'(fx_exp[i]));
		end
		// interrupt raised by a code, cleared by the status read, masked off
		wr_t(REG_CTRL, 32'h0);
		rd_t(REG_STATUS, junk);
		wr_t(REG_MASK, 32'h1);
		code_chk(4'h9, 6000, 16'd13107);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h1);
		rd_chk(REG_STATUS, 32'h1);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		wr_t(REG_MASK, 32'h0);
		code_chk(4'h9, 6000, 16'd13107);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		// channel five gets its own code; a field sample while busy is dropped
		wr_t(REG_RANGE, 32'h00a99999);
		i = n_codes;
		@(posedge mclk);
		sample_ch <= 4'h5;
		sample_data <= 24'sh007d00;
		sample_valid <= 1'b1;
		@(posedge mclk);
		sample_ch <= 4'h0;
		@(posedge mclk);
		chk({31'h0, sample_ready}, 32'h0);
		sample_valid <= 1'b0;
		repeat (4) @(posedge mclk);
		chk(32'(n_codes - i), 32'h1);
		chk({13'h0000, last_ch, last_code}, 32'h0005ffff);
		rd_chk(4'hf, 32'h0000ffff);
		// a read-only code register ignores writes
		wr_t(REG_CODE0, 32'h1234);
		rd_chk(REG_CODE0, 32'd13107);
		give_verdict();
	end
endmodule : tcf_top_tb
